// File: core/dds_pkg.sv
// Constants, field layouts and carrier types for the synthesizer serial load block
package dds_pkg;
  localparam int unsigned WORD_W  = 16;
  localparam int unsigned HALF_W  = 14;
  localparam int unsigned FREQ_W  = 28;
  localparam int unsigned PHASE_W = 12;
  localparam int unsigned CNT_W   = 4;
  // Master clock cycles from a selection or load to the output
  localparam int unsigned PIPE_LAT = 8;
  // Prefix field of a serial word
  localparam int unsigned PFX_HI = 15;
  localparam int unsigned PFX_LO = 14;
  // Bit 13 of a phase word picks the second phase register
  localparam int unsigned PHASE_SEL_BIT = 13;
  localparam logic [CNT_W-1:0]   LAST_BIT     = 4'hF;
  localparam logic [HALF_W-1:0]  CTRL_RST     = 14'h0000;
  localparam logic [FREQ_W-1:0]  FREQ_RST     = 28'h0000000;
  localparam logic [PHASE_W-1:0] PHASE_RST    = 12'h000;
  localparam logic [PHASE_W-1:0] DAC_CLEAR    = 12'h000;

  typedef enum logic [1:0] {
    ADDR_CTRL   = 2'b00,
    ADDR_FREQ_A = 2'b01,
    ADDR_FREQ_B = 2'b10,
    ADDR_PHASE  = 2'b11
  } addr_e;

  // Control bits 13 down to 0
  typedef struct packed {
    logic full_word_load;
    logic half_select;
    logic freq_select_bit;
    logic phase_select_bit;
    logic control_source;
    logic reset_bit;
    logic sleep_clk;
    logic sleep_dac;
    logic sign_output_enable;
    logic comparator_route;
    logic div2;
    logic rsvd2;
    logic mode;
    logic rsvd0;
  } ctrl_s;

  // One stage of the output pipeline
  typedef struct packed {
    logic               clr;
    logic               sleep;
    logic [FREQ_W-1:0]  inc;
    logic [PHASE_W-1:0] off;
  } pipe_s;
endpackage : dds_pkg

// File: core/dds_serial_control_load.sv
// Serial word port, control decode, register load and output pipeline
`timescale 1ns/10ps

module dds_serial_control_load
#(
  parameter int unsigned LATENCY = dds_pkg::PIPE_LAT
) (
  input  wire logic                        sys_clk,
  input  wire logic                        rst_b,
  input  wire logic                        sclk_pin,
  input  wire logic                        frame_sync_n,
  input  wire logic                        sdata_pin,
  input  wire logic                        freq_select_pin,
  input  wire logic                        phase_select_pin,
  input  wire logic                        reset_pin,
  input  wire logic                        power_down_pin,
  input  wire logic                        comparator_in,
  output logic      [dds_pkg::PHASE_W-1:0] dac_code,
  output logic                             dac_power_down,
  output logic                             sign_out,
  output logic                             sign_oe_n
);
  import dds_pkg::*;

  // ==========================================================
  // Reset release and input synchronisers
  logic [1:0] rst_sync_r;
  logic       rst_q;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_q = rst_sync_r[1];

  localparam int unsigned NSYNC = 8;
  logic [NSYNC-1:0] pin_meta_r;
  logic [NSYNC-1:0] pin_sync_r;
  logic             sclk_last_r;
  always_ff @(posedge sys_clk or negedge rst_q) begin
    if (!rst_q) begin
      pin_meta_r  <= 8'hFF;
      pin_sync_r  <= 8'hFF;
      sclk_last_r <= 1'b1;
    end else begin
      pin_meta_r  <= {sclk_pin, frame_sync_n, sdata_pin, freq_select_pin,
                      phase_select_pin, reset_pin, power_down_pin, comparator_in};
      pin_sync_r  <= pin_meta_r;
      sclk_last_r <= pin_sync_r[7];
    end
  end

  logic sclk_s, frame_sync_n_n_s, sdata_s, freq_select_bit_s, psel_s, rst_pin_s, pdn_s, cmp_s;
  assign {sclk_s, frame_sync_n_n_s, sdata_s, freq_select_bit_s, psel_s, rst_pin_s, pdn_s, cmp_s} = pin_sync_r;

  // ==========================================================
  // Serial shift register
  logic              sclk_fall;
  logic [CNT_W-1:0]  bit_cnt_r;
  logic [WORD_W-1:0] shift_r;
  logic [WORD_W-1:0] word_nxt;
  logic              word_stb_r;
  logic [WORD_W-1:0] word_r;

  // A rising frame sync with a partial word simply drops those bits
  assign sclk_fall = sclk_last_r & ~sclk_s & ~frame_sync_n_n_s;
  assign word_nxt  = {shift_r[WORD_W-2:0], sdata_s};

  always_ff @(posedge sys_clk or negedge rst_q) begin
    if (!rst_q) begin
      bit_cnt_r  <= '0;
      shift_r    <= '0;
      word_stb_r <= 1'b0;
      word_r     <= '0;
    end else begin
      word_stb_r <= 1'b0;
      if (frame_sync_n_n_s) begin
        bit_cnt_r <= '0;
      end else if (sclk_fall) begin
        shift_r   <= word_nxt;
        bit_cnt_r <= bit_cnt_r + 4'h1;
        if (bit_cnt_r == LAST_BIT) begin
          word_stb_r <= 1'b1;
          word_r     <= word_nxt;
        end
      end
    end
  end

  // ==========================================================
  // Word decode and programmed registers
  ctrl_s              control_word;
  logic [FREQ_W-1:0]  freq_r [2];
  logic [PHASE_W-1:0] phase_r [2];
  logic               half_pend_r;
  logic               pend_addr_r;
  logic [HALF_W-1:0]  low_hold_r;
  addr_e              word_addr;
  logic [HALF_W-1:0]  word_data;
  logic               fidx;

  assign word_addr = addr_e'(word_r[PFX_HI:PFX_LO]);
  assign word_data = word_r[HALF_W-1:0];
  assign fidx      = word_r[PFX_HI];

  always_ff @(posedge sys_clk or negedge rst_q) begin
    if (!rst_q) begin
      control_word <= CTRL_RST;
    end else if (word_stb_r && word_addr == ADDR_CTRL) begin
      control_word <= word_data;
    end
  end

  // Pending first half is dropped once single-write mode returns
  always_ff @(posedge sys_clk or negedge rst_q) begin
    if (!rst_q) begin
      freq_r[0]   <= FREQ_RST;
      freq_r[1]   <= FREQ_RST;
      phase_r[0]  <= PHASE_RST;
      phase_r[1]  <= PHASE_RST;
      half_pend_r <= 1'b0;
      pend_addr_r <= 1'b0;
      low_hold_r  <= '0;
    end else begin
      if (!control_word.full_word_load) begin
        half_pend_r <= 1'b0;
      end
      if (word_stb_r) begin
        unique case (word_addr)
          ADDR_CTRL: begin
          end
          ADDR_FREQ_A, ADDR_FREQ_B: begin
            if (control_word.full_word_load) begin
              if (half_pend_r && pend_addr_r == fidx) begin
                freq_r[fidx] <= {word_data, low_hold_r};
                half_pend_r  <= 1'b0;
              end else begin
                low_hold_r  <= word_data;
                pend_addr_r <= fidx;
                half_pend_r <= 1'b1;
              end
            end else if (control_word.half_select) begin
              freq_r[fidx][FREQ_W-1:HALF_W] <= word_data;
            end else begin
              freq_r[fidx][HALF_W-1:0] <= word_data;
            end
          end
          ADDR_PHASE: begin
            phase_r[word_r[PHASE_SEL_BIT]] <= word_r[PHASE_W-1:0];
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Late sampling of control and function sources
  ctrl_s ctrl_smp_r;
  logic  clr_src, sleep_src, freq_select_bit_src, psel_src;
  logic  clr_hold_r, sleep_hold_r;

  always_ff @(posedge sys_clk or negedge rst_q) begin
    if (!rst_q) begin
      ctrl_smp_r <= CTRL_RST;
    end else begin
      ctrl_smp_r <= control_word;
    end
  end

  assign clr_src   = ctrl_smp_r.control_source ? rst_pin_s : ctrl_smp_r.reset_bit;
  assign sleep_src = ctrl_smp_r.control_source ? pdn_s : ctrl_smp_r.sleep_clk;
  assign freq_select_bit_src  = ctrl_smp_r.control_source ? freq_select_bit_s : ctrl_smp_r.freq_select_bit;
  assign psel_src  = ctrl_smp_r.control_source ? psel_s : ctrl_smp_r.phase_select_bit;

  // Release is seen one sample late, assertion is immediate
  always_ff @(posedge sys_clk or negedge rst_q) begin
    if (!rst_q) begin
      clr_hold_r   <= 1'b1;
      sleep_hold_r <= 1'b0;
    end else begin
      clr_hold_r   <= clr_src;
      sleep_hold_r <= sleep_src;
    end
  end

  // ==========================================================
  // Output pipeline: LATENCY-1 stages plus the output stage
  pipe_s pipe_in;
  pipe_s pipe_r [LATENCY-1];
  assign pipe_in.clr   = clr_src | clr_hold_r;
  assign pipe_in.sleep = sleep_src | sleep_hold_r;
  assign pipe_in.inc   = freq_r[freq_select_bit_src];
  assign pipe_in.off   = phase_r[psel_src];

  genvar gi;
  generate
    for (gi = 0; gi < LATENCY - 1; gi++) begin : g_pipe
      always_ff @(posedge sys_clk or negedge rst_q) begin
        if (!rst_q) begin
          pipe_r[gi] <= '{clr: 1'b1, sleep: 1'b0, inc: FREQ_RST, off: PHASE_RST};
        end else begin
          pipe_r[gi] <= (gi == 0) ? pipe_in : pipe_r[(gi == 0) ? 0 : gi - 1];
        end
      end
    end
  endgenerate

  pipe_s              pipe_out;
  logic [FREQ_W-1:0]  acc_r;
  logic [PHASE_W-1:0] phase_sum;
  logic [PHASE_W-1:0] code_nxt;
  assign pipe_out  = pipe_r[LATENCY-2];
  assign phase_sum = acc_r[FREQ_W-1 -: PHASE_W] + pipe_out.off;
  // Mode bypasses the late sample: it steers the output directly
  assign code_nxt  = control_word.mode ?
                     (phase_sum[PHASE_W-1] ? ~{phase_sum[PHASE_W-2:0], 1'b0}
                                           : {phase_sum[PHASE_W-2:0], 1'b0})
                     : phase_sum;

  always_ff @(posedge sys_clk or negedge rst_q) begin
    if (!rst_q) begin
      acc_r    <= FREQ_RST;
      dac_code <= DAC_CLEAR;
    end else if (pipe_out.clr) begin
      acc_r    <= FREQ_RST;
      dac_code <= DAC_CLEAR;
    end else if (!pipe_out.sleep) begin
      acc_r    <= acc_r + pipe_out.inc;
      dac_code <= code_nxt;
    end
  end

  // ==========================================================
  // Sign output and converter power-down
  logic msb_last_r, msb_half_r;
  always_ff @(posedge sys_clk or negedge rst_q) begin
    if (!rst_q) begin
      msb_last_r     <= 1'b0;
      msb_half_r     <= 1'b0;
      sign_out       <= 1'b0;
      sign_oe_n      <= 1'b1;
      dac_power_down <= 1'b0;
    end else begin
      msb_last_r <= dac_code[PHASE_W-1];
      if (dac_code[PHASE_W-1] && !msb_last_r) begin
        msb_half_r <= ~msb_half_r;
      end
      sign_oe_n <= ~ctrl_smp_r.sign_output_enable;
      if (ctrl_smp_r.comparator_route) begin
        sign_out <= cmp_s;
      end else begin
        sign_out <= ctrl_smp_r.div2 ? dac_code[PHASE_W-1] : msb_half_r;
      end
      dac_power_down <= ctrl_smp_r.control_source ? pdn_s : ctrl_smp_r.sleep_dac;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_q);

  sequence s_word_ctrl;
    word_stb_r && word_addr == ADDR_CTRL;
  endsequence

  sequence s_first_half;
    word_stb_r && control_word.full_word_load && !half_pend_r
      && word_r[PFX_HI -: 2] != 2'b00 && word_addr != ADDR_PHASE;
  endsequence

  sequence s_second_half;
    word_stb_r && control_word.full_word_load && half_pend_r && pend_addr_r == fidx
      && word_addr != ADDR_CTRL && word_addr != ADDR_PHASE;
  endsequence

  AST_FRAME_IDLE: assert property (frame_sync_n_n_s |=> bit_cnt_r == '0)
    else $error("bit count not cleared outside frame");
  AST_WORD_16: assert property (word_stb_r
      |-> $past(bit_cnt_r) == LAST_BIT && $past(sclk_fall))
    else $error("word completed on wrong edge count");
  AST_CTRL_LOAD: assert property (s_word_ctrl |=> control_word == $past(word_data))
    else $error("control word not loaded");
  AST_NO_PARTIAL: assert property (s_first_half
      |=> $stable(freq_r[0]) && $stable(freq_r[1]))
    else $error("frequency changed on first half");
  AST_TWO_WRITE: assert property (s_first_half
      ##1 (!word_stb_r)[*1] ##0 1 |-> half_pend_r)
    else $error("first half not held");
  AST_FULL_LOAD: assert property (s_second_half
      |=> ($past(fidx) ? freq_r[1] : freq_r[0]) == {$past(word_data), $past(low_hold_r)})
    else $error("second half did not load the full word");
  AST_HALF_UPPER: assert property (word_stb_r && word_addr == ADDR_FREQ_A
      && !control_word.full_word_load && control_word.half_select
      |=> freq_r[0][FREQ_W-1:HALF_W] == $past(word_data)
      && freq_r[0][HALF_W-1:0] == $past(freq_r[0][HALF_W-1:0]))
    else $error("upper half load wrong");
  AST_HALF_LOWER: assert property (word_stb_r && word_addr == ADDR_FREQ_A
      && !control_word.full_word_load && !control_word.half_select
      |=> freq_r[0][HALF_W-1:0] == $past(word_data)
      && freq_r[0][FREQ_W-1:HALF_W] == $past(freq_r[0][FREQ_W-1:HALF_W]))
    else $error("lower half load wrong");
  AST_PHASE_LOAD: assert property (word_stb_r && word_addr == ADDR_PHASE
      |=> ($past(word_r[PHASE_SEL_BIT]) ? phase_r[1] : phase_r[0])
      == $past(word_r[PHASE_W-1:0]))
    else $error("phase word not loaded");
  AST_LATENCY: assert property (pipe_out.inc == $past(pipe_in.inc, 7))
    else $error("pipeline latency not seven stages");
  AST_CLR_OUT: assert property (pipe_in.clr ##7 1 |=> dac_code == DAC_CLEAR)
    else $error("output not cleared after reset");
  AST_REL_LATE: assert property ($fell(clr_src) |-> pipe_in.clr)
    else $error("reset release not delayed");
  AST_REL_EIGHT: assert property ($fell(pipe_in.clr)
      |-> ##6 pipe_out.clr ##1 !pipe_out.clr)
    else $error("output not released eight cycles after reset");
  AST_SLEEP_LATE: assert property ($fell(sleep_src) |-> pipe_in.sleep)
    else $error("sleep release not delayed");
  AST_CLR_ACC: assert property (pipe_out.clr |=> acc_r == FREQ_RST)
    else $error("accumulator not cleared");
  AST_SIGN_CMP: assert property (ctrl_smp_r.comparator_route
      && ctrl_smp_r.sign_output_enable |=> !sign_oe_n && sign_out == $past(cmp_s))
    else $error("comparator not routed to sign output");
  AST_SIGN_OFF: assert property (!ctrl_smp_r.sign_output_enable |=> sign_oe_n)
    else $error("sign output driven while disabled");
endmodule : dds_serial_control_load

// File: verif/dds_host_model.sv
// Serial host model that writes words into the synthesizer load port
`timescale 1ns/10ps
module dds_host_model (
  input  wire logic sys_clk,
  output logic      sclk_pin,
  output logic      frame_sync_n,
  output logic      sdata_pin
);
  // ==========================================================================
  // Frame driver
  // 24 ns half period is six master cycles; clock parks high between frames
  localparam int HALF = 6;

  initial begin
    sclk_pin     = 1'b1;
    frame_sync_n = 1'b1;
    sdata_pin    = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  // Sends n words of 16 bits; fs high clocks the bits with no frame at all
  task automatic send(input logic [15:0] w0, input logic [15:0] w1, input int n,
                      input logic fs);
    logic [31:0] w;
    w = {w0, w1};
    tick(HALF);
    frame_sync_n <= fs;                   // Clock is high at this moment
    for (int i = 0; i < 16 * n; i++) begin // Whole words, one frame
      sdata_pin <= w[31-i];               // MSB first, set while clock high
      tick(HALF);
      sclk_pin <= 1'b0;
      tick(HALF);
      sclk_pin <= 1'b1;
    end
    tick(HALF);
    frame_sync_n <= 1'b1;
    // A released line must not keep looking valid
    sdata_pin <= ~sdata_pin;
  endtask : send
endmodule : dds_host_model

// File: verif/dds_serial_control_load_tb_top.sv
// Self-checking bench for the serial control load block
`timescale 1ns/10ps
module dds_serial_control_load_tb_top;
  import dds_pkg::*;
  logic               sys_clk, rst_b, sclk_pin, frame_sync_n, sdata_pin;
  logic               freq_select_pin, phase_select_pin, reset_pin;
  logic               power_down_pin, comparator_in;
  logic [PHASE_W-1:0] dac_code, c0;
  logic               dac_power_down, sign_out, sign_oe_n;
  int                 errors, num_checks;

  always #2 sys_clk = ~sys_clk;

  dds_host_model host (.sys_clk(sys_clk), .sclk_pin(sclk_pin),
    .frame_sync_n(frame_sync_n), .sdata_pin(sdata_pin));
  dds_serial_control_load DUT (.sys_clk(sys_clk), .rst_b(rst_b), .sclk_pin(sclk_pin),
    .frame_sync_n(frame_sync_n), .sdata_pin(sdata_pin), .freq_select_pin(freq_select_pin),
    .phase_select_pin(phase_select_pin), .reset_pin(reset_pin),
    .power_down_pin(power_down_pin), .comparator_in(comparator_in), .dac_code(dac_code),
    .dac_power_down(dac_power_down), .sign_out(sign_out), .sign_oe_n(sign_oe_n));

  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] w);
    host.send(w, 16'h0000, 1, 1'b0);
  endtask : wr

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc

  // Frozen accumulator means a still output; phase steps here are large
  task automatic moves(input logic exp);
    logic mv;
    cyc(24);
    c0 = dac_code;
    mv = 1'b0;
    repeat (64) begin
      cyc(1);
      if (dac_code !== c0) mv = 1'b1;
    end
    chk({11'h000, mv}, {11'h000, exp});
  endtask : moves

  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  // ==========================================================================
  // Scenarios
  task automatic t_load;
    wr(16'h0100);                             // Function reset held while loading
    host.send(16'h4000, 16'h1100, 2, 1'b0);
    host.send(16'h4000, 16'hC000, 2, 1'b0);
    wr(16'hE800);
    cyc(24);
    chk(dac_code, DAC_CLEAR);
    wr(16'h0000);
    moves(1'b0);
  endtask : t_load

  task automatic t_halves;
    wr(16'h4001);
    moves(1'b0);
    wr(16'h1000);
    wr(16'h4100);
    moves(1'b1);
    wr(16'h4000);
    moves(1'b0);
  endtask : t_halves

  task automatic t_two;
    wr(16'h2000);
    wr(16'h7FFF);
    moves(1'b0);
    wr(16'h4000);
    moves(1'b1);
    host.send(16'h4000, 16'h4000, 2, 1'b0);
    moves(1'b0);
  endtask : t_two

  task automatic t_sel;
    host.send(16'h8000, 16'h8100, 2, 1'b0);
    wr(16'h2800);
    moves(1'b1);
    wr(16'h2200);
    moves(1'b0);
    @(posedge sys_clk);
    freq_select_pin <= 1'b1;
    moves(1'b1);
    @(posedge sys_clk);
    freq_select_pin <= 1'b0;
    moves(1'b0);
  endtask : t_sel

  task automatic t_phase;
    logic [11:0] c;
    wr(16'h2100);
    cyc(24);
    chk(dac_code, DAC_CLEAR);
    wr(16'h2000);
    cyc(24);
    c = dac_code;
    wr(16'h2400);
    cyc(24);
    chk({11'h000, dac_code !== c}, 12'h001);
    chk(dac_code, 12'h800);
    wr(16'h2800);
    moves(1'b1);
    wr(16'h2200);
    @(posedge sys_clk);
    reset_pin <= 1'b1;
    cyc(24);
    chk(dac_code, DAC_CLEAR);
    @(posedge sys_clk);
    reset_pin <= 1'b0;
  endtask : t_phase

  task automatic t_pwr;
    host.send(16'h0040, 16'h0000, 1, 1'b1);
    cyc(24);
    chk({11'h000, dac_power_down}, 12'h000);
    wr(16'h0040);
    cyc(24);
    chk({11'h000, dac_power_down}, 12'h001);
    wr(16'h0240);
    cyc(24);
    chk({11'h000, dac_power_down}, 12'h000);
    @(posedge sys_clk);
    power_down_pin <= 1'b1;
    cyc(24);
    chk({11'h000, dac_power_down}, 12'h001);
    @(posedge sys_clk);
    power_down_pin <= 1'b0;
  endtask : t_pwr

  task automatic t_sign;
    for (int i = 0; i < 4; i++) begin
      wr({10'h000, i[1:0], 4'h0});
      for (int v = 0; v < 2; v++) begin
        @(posedge sys_clk);
        comparator_in <= v[0];
        cyc(16);
        chk({11'h000, sign_oe_n}, {11'h000, ~i[1]});
        if (i == 3) chk({11'h000, sign_out}, {11'h000, v[0]});
      end
    end
    // Comparator is high here, so the code's MSB must win
    wr(16'h0028);
    cyc(24);
    chk({11'h000, sign_out}, 12'h000);
    wr(16'hC800);
    cyc(24);
    chk({11'h000, sign_out}, 12'h001);
    // Triangle peaks at half phase
    wr(16'h0002);
    cyc(24);
    chk(dac_code, 12'hFFF);
  endtask : t_sign

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    sys_clk = 1'b0;
    rst_b = 1'b0;
    freq_select_pin = 1'b0;
    phase_select_pin = 1'b0;
    reset_pin = 1'b0;
    power_down_pin = 1'b0;
    comparator_in = 1'b0;
    errors = 0;
    num_checks = 0;
    cyc(20);
    @(posedge sys_clk);
    rst_b <= 1'b1;
    cyc(8);
    t_load();
    t_halves();
    t_two();
    t_sel();
    t_phase();
    t_pwr();
    t_sign();
    test_done();
  end

  // Whole run needs about 35 us; a hang is cut well after that
  initial begin
    #200000;
    errors++;
    test_done();
  end
endmodule : dds_serial_control_load_tb_top
